// file: owl_pkg.sv
// Constants shared by the one-wire sensor link
package owl_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int CLK_NS = 4;
	localparam int SMP_HZ = 512_000;
	localparam int SMP_DIV = CLK_HZ / SMP_HZ;
	localparam int RX_MIN_HZ = 6_000;
	localparam logic [7:0] RX_TMO = 8'(2 * SMP_HZ / RX_MIN_HZ);
	localparam int WIN_NS = 3_000_000;
	localparam int WIN_CYC = WIN_NS / CLK_NS;
	localparam int BIT_FAST_NS = 31_250;
	localparam int BIT_SLOW_NS = 125_000;
	localparam int BIT_FAST_CYC = BIT_FAST_NS / CLK_NS;
	localparam int BIT_SLOW_CYC = BIT_SLOW_NS / CLK_NS;
	localparam int IDLE0_NS = 1_000_000;
	localparam int IDLE1_NS = 4_850_000;
	localparam int IDLE2_NS = 22_500_000;
	localparam int IDLE3_NS = 118_000_000;
	localparam int IDLE0_CYC = IDLE0_NS / CLK_NS;
	localparam int IDLE1_CYC = IDLE1_NS / CLK_NS;
	localparam int IDLE2_CYC = IDLE2_NS / CLK_NS;
	localparam int IDLE3_CYC = IDLE3_NS / CLK_NS;
	// ----------------------------------------------------------------
	// Frame and packet layout
	// ----------------------------------------------------------------
	localparam logic [4:0] RX_LAST_RISE = 5'd18;
	localparam logic [3:0] TX_LAST_BIT = 4'd9;
	localparam logic [7:0] ACK_BYTE = 8'ha5;
	localparam logic [4:0] EE_LAST = 5'd19;
	localparam logic [1:0] PKT_LAST_BR = 2'd1;
	localparam logic [1:0] PKT_LAST_TMP = 2'd2;
	localparam logic [7:0] SPEC_P0 = 8'd128;
	localparam logic [7:0] SPEC_P1 = 8'd64;
	localparam logic [7:0] SPEC_P2 = 8'd16;
	localparam logic [7:0] SPEC_P3 = 8'd8;
	// ----------------------------------------------------------------
	// State encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_WINDOW = 2'b00,
		MODE_CMD = 2'b01,
		MODE_RUN = 2'b10
	} owl_mode_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_LOW = 3'b001,
		TX_HIGH = 3'b010,
		TX_STOP = 3'b011,
		TX_GAP = 3'b100
	} owl_tx_t;
endpackage

// file: owl_link.sv
// One-wire sensor link: receiver, mode control, packet transmitter
`timescale 1ns/1ps
`default_nettype none
module owl_link #(
	parameter int WIN_CYC = owl_pkg::WIN_CYC,
	parameter int BIT_FAST_CYC = owl_pkg::BIT_FAST_CYC,
	parameter int BIT_SLOW_CYC = owl_pkg::BIT_SLOW_CYC,
	parameter int IDLE0_CYC = owl_pkg::IDLE0_CYC,
	parameter int IDLE1_CYC = owl_pkg::IDLE1_CYC,
	parameter int IDLE2_CYC = owl_pkg::IDLE2_CYC,
	parameter int IDLE3_CYC = owl_pkg::IDLE3_CYC,
	parameter logic [7:0] ENTER_CM_CODE = 8'h01, // Arbitrary value
	parameter logic [7:0] ENTER_RUN_CODE = 8'h02, // Arbitrary value
	parameter int BUF_DEPTH = 2,
	parameter int SMP_DIV = owl_pkg::SMP_DIV // Clocks per sample tick
) (
	input wire logic sys_clk, // System clock
	input wire logic rst_b, // Async reset
	input wire logic line_in, // Wire level from pad
	output logic line_out, // Level driven onto wire
	output logic line_oe_b, // Low while driving wire
	output logic pullup_en, // Internal pull-up on
	output logic power_down, // Power down in idle gap at slow update rates in run mode
	input wire logic [1:0] update_rate, // Update rate setting
	input wire logic digital_out, // Digital output selected
	input wire logic temp_out, // Add temperature byte
	input wire logic meas_valid, // New bridge result
	input wire logic [13:0] bridge_val, // Bridge value
	input wire logic [7:0] temp_val, // Temperature value
	input wire logic diag_fault, // Diagnostic fault seen
	output logic temp_meas_req, // Do special measurement
	output logic cmd_valid, // Command to execute
	output logic [7:0] cmd_code, // Command byte
	output logic [7:0] cmd_arg, // Data byte
	input wire logic cmd_done, // Command executed ok
	input wire logic ee_valid, // Stored byte offered
	input wire logic [7:0] ee_data, // Stored byte
	output logic ee_ready, // Stored byte taken
	output logic [1:0] mode // Current mode
);
	localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CW = 25;

	if (BUF_DEPTH < 2 || WIN_CYC < 8 || BIT_FAST_CYC < 8 ||
		BIT_SLOW_CYC < 8 || IDLE3_CYC >= 2 ** CW || SMP_DIV < 2 ||
		SMP_DIV > 512) begin : g_chk
		$error("owl_link: parameter out of range");
	end

	// Bit period for the programmed update rate
	function automatic logic [CW-1:0] bit_cyc(input logic [1:0] r);
		bit_cyc = r[1] ? CW'(BIT_SLOW_CYC) : CW'(BIT_FAST_CYC);
	endfunction

	// ----------------------------------------------------------------
	// Wire sampling
	// ----------------------------------------------------------------
	logic sync1_q, sync2_q, lvl_q;
	logic [8:0] smp_cnt_q;
	logic smp_tick, fall, rise;
	assign smp_tick = (smp_cnt_q == 9'(SMP_DIV - 1));
	assign fall = smp_tick & lvl_q & ~sync2_q;
	assign rise = smp_tick & ~lvl_q & sync2_q;

	// Two flops ahead of any decoding
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= line_in;
			sync2_q <= sync1_q;
		end
	end

	// Sample tick divider
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			smp_cnt_q <= '0;
		else
			smp_cnt_q <= smp_tick ? 9'd0 : smp_cnt_q + 9'd1;
	end

	// ----------------------------------------------------------------
	// Frame receiver
	// ----------------------------------------------------------------
	owl_pkg::owl_mode_t mode_q;
	owl_pkg::owl_tx_t tx_st_q;
	logic rx_act_q, frm_done_q, rx_en, par_ok, frm_ok;
	logic [7:0] rx_tm_q, rx_ref_q;
	logic [4:0] rx_n_q;
	logic [17:0] rx_sh_q;
	// Our own transmission must not be decoded as a frame
	assign rx_en = line_oe_b && mode_q != owl_pkg::MODE_RUN;
	assign par_ok = !(^rx_sh_q[17:9]) && !(^rx_sh_q[8:0]);
	assign frm_ok = frm_done_q & par_ok;

	// Each bit's low time is judged against the start bit's low time
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl_q <= 1'b1;
			rx_act_q <= 1'b0;
			frm_done_q <= 1'b0;
			rx_tm_q <= '0;
			rx_ref_q <= '0;
			rx_n_q <= '0;
			rx_sh_q <= '0;
		end else begin
			frm_done_q <= 1'b0;
			if (smp_tick)
				lvl_q <= sync2_q;
			if (!rx_en) begin
				rx_act_q <= 1'b0;
			end else if (!rx_act_q) begin
				if (fall) begin
					rx_act_q <= 1'b1;
					rx_tm_q <= '0;
					rx_n_q <= '0;
				end
			end else if (smp_tick) begin
				if (rx_tm_q == owl_pkg::RX_TMO) begin
					rx_act_q <= 1'b0;
				end else begin
					rx_tm_q <= fall ? 8'd0 : rx_tm_q + 8'd1;
					if (rise) begin
						if (rx_n_q == 5'd0)
							rx_ref_q <= rx_tm_q;
						else
							rx_sh_q <= {rx_sh_q[16:0], rx_tm_q < rx_ref_q};
						rx_n_q <= rx_n_q + 5'd1;
						if (rx_n_q == owl_pkg::RX_LAST_RISE) begin
							rx_act_q <= 1'b0;
							frm_done_q <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode control and command hand-off
	// ----------------------------------------------------------------
	logic [CW-1:0] win_q;
	logic cmd_valid_q, ack_q, ack_set, ack_push, in_ready;
	logic [7:0] code_q, arg_q;
	logic is_cm, is_run;
	assign is_cm = rx_sh_q[17:10] == ENTER_CM_CODE;
	assign is_run = rx_sh_q[17:10] == ENTER_RUN_CODE;

	// Entry into command mode exists only inside the window
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= owl_pkg::MODE_WINDOW;
			win_q <= '0;
			cmd_valid_q <= 1'b0;
			code_q <= '0;
			arg_q <= '0;
		end else begin
			cmd_valid_q <= 1'b0;
			case (mode_q)
				owl_pkg::MODE_WINDOW: begin
					if (frm_ok && is_cm)
						mode_q <= owl_pkg::MODE_CMD;
					else if (win_q == CW'(WIN_CYC - 1))
						mode_q <= owl_pkg::MODE_RUN;
					win_q <= win_q + 1'b1;
				end
				owl_pkg::MODE_CMD: begin
					if (frm_ok && is_run) begin
						mode_q <= owl_pkg::MODE_RUN;
					end else if (frm_ok) begin
						cmd_valid_q <= 1'b1;
						code_q <= rx_sh_q[17:10];
						arg_q <= rx_sh_q[8:1];
					end
				end
				owl_pkg::MODE_RUN: ;
				default: mode_q <= owl_pkg::MODE_RUN;
			endcase
		end
	end

	// Ack pending; a new set wins over the clear of the last one
	assign ack_set = frm_ok && ((mode_q == owl_pkg::MODE_WINDOW && is_cm) ||
		(mode_q == owl_pkg::MODE_CMD && is_run) ||
		(mode_q == owl_pkg::MODE_CMD && cmd_done));
	assign ack_push = ack_q & in_ready;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= ack_set | (ack_q & ~ack_push)
				| (mode_q == owl_pkg::MODE_CMD && cmd_done);
	end

	// ----------------------------------------------------------------
	// Packet builder
	// ----------------------------------------------------------------
	logic pkt_act_q, pkt_pop, push_valid, tmr;
	logic [1:0] pkt_idx_q, pkt_last_q;
	logic [13:0] pb_q;
	logic [7:0] pt_q, spec_q, spec_p;
	logic pf_q;
	logic [4:0] ee_cnt_q;
	logic [9:0] push_word;
	assign tmr = mode_q != owl_pkg::MODE_CMD;
	assign pkt_pop = pkt_act_q & ~ack_q & tmr & in_ready;

	// Ack first, then stored bytes, then measurement packets
	always_comb begin
		push_valid = 1'b0;
		push_word = '0;
		ee_ready = 1'b0;
		if (ack_q) begin
			push_valid = 1'b1;
			push_word = {2'b01, owl_pkg::ACK_BYTE};
		end else if (!tmr) begin
			ee_ready = in_ready;
			push_valid = ee_valid;
			push_word = {1'b0, ee_cnt_q == owl_pkg::EE_LAST, ee_data};
		end else if (pkt_act_q) begin
			push_valid = 1'b1;
			push_word[9:8] = {pf_q, pkt_idx_q == pkt_last_q};
			case (pkt_idx_q)
				2'd0: push_word[7:0] = {2'b00, pb_q[13:8]};
				2'd1: push_word[7:0] = pb_q[7:0];
				default: push_word[7:0] = pt_q;
			endcase
		end
	end

	// Count stored bytes so every 20th closes a packet
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ee_cnt_q <= '0;
		else if (ee_valid && ee_ready)
			ee_cnt_q <= (ee_cnt_q == owl_pkg::EE_LAST) ? 5'd0 : ee_cnt_q + 5'd1;
	end

	// A result arriving while a packet drains is dropped; newest wins next
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pkt_act_q <= 1'b0;
			pkt_idx_q <= '0;
			pkt_last_q <= '0;
			pb_q <= '0;
			pt_q <= '0;
			pf_q <= 1'b0;
		end else if (!pkt_act_q) begin
			if (meas_valid && digital_out && mode_q == owl_pkg::MODE_RUN) begin
				pkt_act_q <= 1'b1;
				pkt_idx_q <= '0;
				pkt_last_q <= temp_out ? owl_pkg::PKT_LAST_TMP
					: owl_pkg::PKT_LAST_BR;
				pb_q <= bridge_val;
				pt_q <= temp_val;
				pf_q <= diag_fault;
			end
		end else if (pkt_pop) begin
			pkt_act_q <= pkt_idx_q != pkt_last_q;
			pkt_idx_q <= pkt_idx_q + 2'd1;
		end
	end

	// Special measurement every N bridge results
	always_comb begin
		case (update_rate)
			2'b00: spec_p = owl_pkg::SPEC_P0;
			2'b01: spec_p = owl_pkg::SPEC_P1;
			2'b10: spec_p = owl_pkg::SPEC_P2;
			default: spec_p = owl_pkg::SPEC_P3;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			spec_q <= '0;
			temp_meas_req <= 1'b0;
		end else begin
			temp_meas_req <= 1'b0;
			if (meas_valid && mode_q == owl_pkg::MODE_RUN) begin
				temp_meas_req <= spec_q >= spec_p - 8'd1;
				spec_q <= (spec_q >= spec_p - 8'd1) ? 8'd0 : spec_q + 8'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Two-entry buffer between builder and transmitter
	// ----------------------------------------------------------------
	logic [9:0] mem_q [BUF_DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic out_valid, pop, push;
	assign in_ready = cnt_q != (AW + 1)'(BUF_DEPTH);
	assign out_valid = cnt_q != '0;
	assign push = push_valid & in_ready;

	// A stalled transmitter fills it and holds the builder back
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= (wp_q == AW'(BUF_DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(BUF_DEPTH - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (push)
			mem_q[wp_q] <= push_word;
	end

	// ----------------------------------------------------------------
	// Byte transmitter
	// ----------------------------------------------------------------
	logic [CW-1:0] tx_cnt_q, t_bit, t_low, t_gap;
	logic [3:0] tx_bit_q;
	logic [8:0] tx_sh_q;
	logic tx_last_q;
	logic [9:0] head;
	assign head = mem_q[rp_q];
	assign t_bit = bit_cyc(update_rate);
	assign pop = out_valid && (tx_st_q == owl_pkg::TX_IDLE ||
		(tx_st_q == owl_pkg::TX_STOP && tx_cnt_q >= (t_bit >> 1) - 1'b1));

	// Low share: half for start, quarter for one, three quarters for zero
	always_comb begin
		if (tx_bit_q == 4'd0)
			t_low = t_bit >> 1;
		else if (tx_sh_q[8])
			t_low = t_bit >> 2;
		else
			t_low = t_bit - (t_bit >> 2);
		if (mode_q != owl_pkg::MODE_RUN)
			t_gap = t_bit;
		else case (update_rate)
			2'b00: t_gap = CW'(IDLE0_CYC);
			2'b01: t_gap = CW'(IDLE1_CYC);
			2'b10: t_gap = CW'(IDLE2_CYC);
			default: t_gap = CW'(IDLE3_CYC);
		endcase
	end

	// Ten bits a byte; half-bit stop inside a packet, idle gap after it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_q <= owl_pkg::TX_IDLE;
			tx_cnt_q <= '0;
			tx_bit_q <= '0;
			tx_sh_q <= '0;
			tx_last_q <= 1'b0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 1'b1;
			if (pop) begin
				tx_st_q <= owl_pkg::TX_LOW;
				tx_cnt_q <= '0;
				tx_bit_q <= '0;
				tx_sh_q <= {head[7:0], ^head[7:0] ^ head[9]};
				tx_last_q <= head[8];
			end else case (tx_st_q)
				owl_pkg::TX_IDLE: tx_cnt_q <= '0;
				owl_pkg::TX_LOW: begin
					if (tx_cnt_q >= t_low - 1'b1)
						tx_st_q <= owl_pkg::TX_HIGH;
				end
				owl_pkg::TX_HIGH: begin
					if (tx_cnt_q >= t_bit - 1'b1) begin
						tx_cnt_q <= '0;
						if (tx_bit_q == owl_pkg::TX_LAST_BIT) begin
							tx_st_q <= tx_last_q ? owl_pkg::TX_GAP
								: owl_pkg::TX_STOP;
						end else begin
							tx_st_q <= owl_pkg::TX_LOW;
							tx_bit_q <= tx_bit_q + 4'd1;
							if (tx_bit_q != 4'd0)
								tx_sh_q <= {tx_sh_q[7:0], 1'b0};
						end
					end
				end
				owl_pkg::TX_STOP: begin
					if (tx_cnt_q >= (t_bit >> 1) - 1'b1)
						tx_cnt_q <= tx_cnt_q; // Hold high until data
				end
				owl_pkg::TX_GAP: begin
					if (tx_cnt_q >= t_gap - 1'b1)
						tx_st_q <= owl_pkg::TX_IDLE;
				end
				default: tx_st_q <= owl_pkg::TX_IDLE;
			endcase
		end
	end

	// Pin and status outputs
	assign line_out = tx_st_q != owl_pkg::TX_LOW;
	assign line_oe_b = !(tx_st_q == owl_pkg::TX_LOW ||
		tx_st_q == owl_pkg::TX_HIGH || tx_st_q == owl_pkg::TX_STOP);
	assign pullup_en = mode_q != owl_pkg::MODE_RUN || digital_out;
	assign power_down = tx_st_q == owl_pkg::TX_GAP && update_rate[1]
		&& mode_q == owl_pkg::MODE_RUN;
	assign cmd_valid = cmd_valid_q;
	assign cmd_code = code_q;
	assign cmd_arg = arg_q;
	assign mode = mode_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	AST_ACK_BYTE: assert property (ack_push |-> push_word[7:0] == 8'ha5
		&& push_word[8]) else $error("ack byte wrong");
	AST_BAD_FRAME: assert property (frm_done_q && !par_ok |=>
		!cmd_valid_q && ((mode_q == owl_pkg::MODE_CMD) ==
		($past(mode_q) == owl_pkg::MODE_CMD))) else $error("bad frame used");
	AST_WIN_EXIT: assert property (mode_q == owl_pkg::MODE_WINDOW &&
		win_q == CW'(WIN_CYC - 1) && !frm_ok |=> mode_q == owl_pkg::MODE_RUN)
		else $error("window not closed");
	AST_WIN_IGNORE: assert property (mode_q == owl_pkg::MODE_WINDOW &&
		frm_ok && !is_cm |=> mode_q != owl_pkg::MODE_CMD && !cmd_valid_q)
		else $error("window took other command");
	AST_CM_HOLD: assert property (mode_q == owl_pkg::MODE_CMD &&
		!(frm_ok && is_run) |=> mode_q == owl_pkg::MODE_CMD)
		else $error("command mode left");
	AST_BRIDGE_TOP: assert property (pkt_pop && pkt_idx_q == 2'd0 |->
		push_word[7:6] == 2'b00) else $error("bridge top bits set");
	AST_STOP_HIGH: assert property (tx_st_q == owl_pkg::TX_STOP |->
		line_out && !line_oe_b) else $error("stop not high");
	AST_PULLUP: assert property (mode_q == owl_pkg::MODE_WINDOW |->
		pullup_en) else $error("pull-up off in window");
	AST_TMO: assert property (rx_act_q && rx_en && smp_tick &&
		rx_tm_q == owl_pkg::RX_TMO |=> !rx_act_q ##1 !frm_done_q)
		else $error("timeout ignored");

	COV_ENTER_CM: cover property (mode_q == owl_pkg::MODE_WINDOW
		##1 mode_q == owl_pkg::MODE_CMD);
	COV_ACK: cover property (ack_push);
	COV_TEMP_PKT: cover property (pkt_pop && pkt_idx_q == 2'd2);
	COV_GAP: cover property (power_down);
endmodule // owl_link
`default_nettype wire

// file: owl_master_model.sv
// Host-side model of the one-wire link: frame sender and byte decoder
`timescale 1ns/1ps
`default_nettype none
module owl_master_model #(
	parameter int TM = 5400 // Master bit period in sys_clk cycles
) (
	input wire logic sys_clk, // System clock
	input wire logic line_out, // Device drive level
	input wire logic line_oe_b, // Device drive enable, low active
	output logic line_in // Resolved wire level
);
	logic m_low = 1'b0;
	int cyc = 0;
	logic [8:0] rx_q[$];
	int rx_t[$];
	// --------------------------------------------------------------
	// Wire and time base
	// --------------------------------------------------------------
	// Both sides only pull low; the external pull-up wins when released
	assign line_in = ~m_low & (line_oe_b | line_out);
	// Blocking count so decoders woken later in the step see the new value
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
	end
	// --------------------------------------------------------------
	// Frame sender
	// --------------------------------------------------------------
	// One bit: low for lo cycles, high for the rest of the period
	task automatic bit_out(input int lo);
		m_low = 1'b1;
		repeat (lo) @(posedge sys_clk);
		#1 m_low = 1'b0;
		repeat (TM - lo) @(posedge sys_clk);
		#1;
	endtask
	// Called just after a clock edge; bad flips the command parity
	task automatic send_frame(input logic [7:0] c, input logic [7:0] d,
		input logic bad);
		logic [17:0] v;
		int i;
		v = {c, ^c ^ bad, d, ^d};
		bit_out(TM / 2);
		for (i = 17; i >= 0; i--) begin
			bit_out(v[i] ? TM / 4 : 3 * TM / 4);
		end
	endtask
	// --------------------------------------------------------------
	// Byte decoder
	// --------------------------------------------------------------
	// Start low time is the reference; a shorter low reads as 1
	always begin
		int t0;
		int t1;
		int rl;
		int i;
		logic [8:0] b;
		@(negedge line_in iff line_oe_b === 1'b0);
		t0 = cyc;
		@(posedge line_in);
		rl = cyc - t0;
		b = 9'h000;
		for (i = 0; i < 9; i++) begin
			@(negedge line_in);
			t1 = cyc;
			@(posedge line_in);
			b = {b[7:0], (cyc - t1) < rl};
		end
		rx_q.push_back(b);
		rx_t.push_back(t0);
	end
endmodule // owl_master_model
`default_nettype wire

// file: owl_link_tb.sv
// Self-checking testbench of the one-wire sensor link
`timescale 1ns/1ps
`default_nettype none
module owl_link_tb;
	localparam int TM = 88; // Eleven sample ticks a bit, as 46 kHz
	localparam int SD = 8; // Sample tick divider, scaled down for run time
	localparam int WIN = 3000;
	localparam int BF = 64;
	localparam int BS = 128;
	localparam int ID2 = 400;
	logic sys_clk, rst_b, line_in, line_out, line_oe_b, pullup_en;
	logic power_down, digital_out, temp_out, meas_valid, diag_fault;
	logic temp_meas_req, cmd_valid, cmd_done, ee_valid, ee_ready;
	logic [1:0] update_rate, mode;
	logic [13:0] bridge_val;
	logic [7:0] temp_val, cmd_code, cmd_arg, ee_data;
	int bad_count = 0;
	int n_compared = 0;
	int n_cmd = 0;
	int n_req = 0;
	// --------------------------------------------------------------
	// Design, partner and clock
	// --------------------------------------------------------------
	// Short counts keep the run small; only the host's bits and the edge timeout keep a real tick count
	owl_link #(.WIN_CYC(WIN), .BIT_FAST_CYC(BF), .BIT_SLOW_CYC(BS),
		.SMP_DIV(SD),
		.IDLE0_CYC(200), .IDLE1_CYC(300), .IDLE2_CYC(ID2),
		.IDLE3_CYC(500)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.line_in(line_in), .line_out(line_out), .line_oe_b(line_oe_b),
		.pullup_en(pullup_en), .power_down(power_down),
		.update_rate(update_rate), .digital_out(digital_out),
		.temp_out(temp_out), .meas_valid(meas_valid),
		.bridge_val(bridge_val), .temp_val(temp_val),
		.diag_fault(diag_fault), .temp_meas_req(temp_meas_req),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
		.cmd_done(cmd_done), .ee_valid(ee_valid), .ee_data(ee_data),
		.ee_ready(ee_ready), .mode(mode));
	owl_master_model #(.TM(TM)) i_master (.sys_clk(sys_clk),
		.line_out(line_out), .line_oe_b(line_oe_b), .line_in(line_in));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Pulse counters, since both outputs stand for one cycle only
	always @(posedge sys_clk) begin
		if (cmd_valid === 1'b1) n_cmd++;
		if (temp_meas_req === 1'b1) n_req++;
	end
	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic summarize();
		if (bad_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Byte with its even parity, inverted when a fault is flagged
	task automatic chk_byte(input int k, input logic [7:0] d,
		input logic f);
		chk(32'(i_master.rx_q[k]), 32'({d, ^d ^ f}));
	endtask
	// Start to start inside a packet: ten bits plus a half-bit stop
	task automatic chk_gap(input int k, input int t);
		chk(i_master.rx_t[k + 1] - i_master.rx_t[k], 21 * t / 2);
	endtask
	// Bounded wait for decoded bytes; the host gives up like a lost ack
	task automatic wait_rx(input int n);
		int i;
		for (i = 0; i < 200000 && i_master.rx_q.size() < n; i++) step(1);
		if (i_master.rx_q.size() < n) begin
			bad_count++;
			summarize();
		end
	endtask
	// Let the last byte and its gap end before the wire is reused
	task automatic clr();
		step(200);
		i_master.rx_q.delete();
		i_master.rx_t.delete();
	endtask
	task automatic do_reset();
		rst_b = 1'b0;
		step(16);
		rst_b = 1'b1;
		clr();
		n_cmd = 0;
		n_req = 0;
	endtask
	task automatic meas(input logic [13:0] b);
		meas_valid = 1'b1;
		bridge_val = b;
		step(1);
		meas_valid = 1'b0;
	endtask
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	// Silent window, then measurement packets in normal run
	task automatic sc_run_stream();
		int i;
		int n;
		do_reset();
		update_rate = 2'b11;
		step(WIN + 20);
		chk(mode, owl_pkg::MODE_RUN);
		chk(pullup_en, 1'b1);
		for (i = 0; i < 8; i++) begin
			if (i == 7) chk(n_req, 0);
			meas(14'h3a5c);
			step(4000);
		end
		chk(n_req, 1);
		chk_byte(0, 8'h3a, 1'b0);
		chk_gap(0, BS);
		clr();
		update_rate = 2'b00;
		meas(14'h3a5c);
		wait_rx(2);
		chk_byte(0, 8'h3a, 1'b0);
		chk_byte(1, 8'h5c, 1'b0);
		chk_gap(0, BF);
		step(2000);
		clr();
		update_rate = 2'b01;
		temp_out = 1'b1;
		diag_fault = 1'b1;
		temp_val = 8'hc3;
		meas(14'h0123);
		wait_rx(3);
		chk_byte(0, 8'h01, 1'b1);
		chk_byte(1, 8'h23, 1'b1);
		chk_byte(2, 8'hc3, 1'b1);
		chk_gap(1, BF);
		temp_out = 1'b0;
		diag_fault = 1'b0;
		step(2000);
		update_rate = 2'b10;
		meas(14'h1000);
		for (i = 0; i < 5000 && power_down !== 1'b1; i++) step(1);
		if (i == 5000) begin
			bad_count++;
			summarize();
		end
		for (n = 0; n < 5000 && power_down === 1'b1; n++) step(1);
		chk(n >= ID2 - 2 && n <= ID2 + 2, 1'b1);
	endtask
	// Entry in window, refused and good frames, ack and stored stream
	task automatic sc_cmd_mode();
		int k;
		int j;
		update_rate = 2'b00;
		do_reset();
		i_master.send_frame(8'h01, 8'h00, 1'b0);
		chk(mode, owl_pkg::MODE_CMD);
		wait_rx(1);
		chk_byte(0, 8'ha5, 1'b0);
		chk(pullup_en, 1'b1);
		clr();
		i_master.send_frame(8'h30, 8'h41, 1'b1);
		// Cut frame: start and one bit, then silence past the edge timeout
		i_master.bit_out(TM / 2);
		i_master.bit_out(TM / 4);
		step(3000);
		chk(n_cmd, 0);
		chk(i_master.rx_q.size(), 0);
		i_master.send_frame(8'h30, 8'h41, 1'b0);
		chk(n_cmd, 1);
		chk({cmd_code, cmd_arg}, 16'h3041);
		step(2000);
		chk(i_master.rx_q.size(), 0);
		cmd_done = 1'b1;
		step(1);
		cmd_done = 1'b0;
		wait_rx(1);
		chk_byte(0, 8'ha5, 1'b0);
		clr();
		for (k = 0; k < 20; k++) begin
			ee_valid = 1'b1;
			ee_data = 8'h40 + 8'(k);
			for (j = 0; j < 5000; j++) begin
				@(posedge sys_clk);
				if (ee_ready === 1'b1) break;
			end
			#1;
			if (j == 5000) begin
				chk(k, 20);
				summarize();
			end
		end
		ee_valid = 1'b0;
		wait_rx(20);
		for (k = 0; k < 19; k++) begin
			chk_byte(k, 8'h40 + 8'(k), 1'b0);
			chk_gap(k, BF);
		end
		chk_byte(19, 8'h53, 1'b0);
		step(WIN);
		chk(mode, owl_pkg::MODE_CMD);
		clr();
		i_master.send_frame(8'h02, 8'h00, 1'b0);
		chk(mode, owl_pkg::MODE_RUN);
		wait_rx(1);
		chk_byte(0, 8'ha5, 1'b0);
	endtask
	// A command other than the entry command inside the window
	task automatic sc_window_ignore();
		do_reset();
		i_master.send_frame(8'h30, 8'h41, 1'b0);
		chk(n_cmd, 0);
		chk(mode, owl_pkg::MODE_WINDOW);
		step(WIN);
		chk(mode, owl_pkg::MODE_RUN);
		chk(i_master.rx_q.size(), 0);
		digital_out = 1'b0;
		step(1);
		chk(pullup_en, 1'b0);
		digital_out = 1'b1;
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		update_rate = 2'b00;
		digital_out = 1'b1;
		temp_out = 1'b0;
		meas_valid = 1'b0;
		bridge_val = 14'h0000;
		temp_val = 8'h00;
		diag_fault = 1'b0;
		cmd_done = 1'b0;
		ee_valid = 1'b0;
		ee_data = 8'h00;
		sc_run_stream();
		sc_cmd_mode();
		sc_window_ignore();
		summarize();
	end
endmodule // owl_link_tb
`default_nettype wire
